// >>> logic/sct_pkg.sv
// Shared constants, pin bundle and command encodings for the SDRAM device timing block
package sct_pkg;

    // Data and address pin widths
    localparam int DATA_W = 8;
    localparam int ADDR_W = 12;

    // Address field positions
    localparam int BANK_BIT    = 11;   // Bank select line
    localparam int PRE_ALL_BIT = 10;   // Precharge both banks
    localparam int CL_LSB      = 4;    // Mode word: latency field
    localparam int CL_W        = 3;
    localparam int BL_LSB      = 0;    // Mode word: burst length field
    localparam int BL_W        = 3;

    // Burst length codes
    localparam logic [BL_W-1:0] BL_FULL_PAGE = 3'h7;
    localparam logic [BL_W-1:0] BL_MAX_POW   = 3'h3;

    // Values after reset, and the refresh tally limit
    localparam logic [CL_W-1:0] RST_CAS_LATENCY = 3'h3;
    localparam logic [BL_W-1:0] RST_BURST_CODE  = 3'h0;
    localparam logic            RST_CKE_LAST    = 1'h1;
    localparam logic [3:0]      REFRESH_SAT     = 4'hF;

    // Latency figures, counted in link clock edges
    localparam int MASK_READ_DISABLE_LATENCY = 2;
    localparam int MASK_WRITE_LATENCY        = 0;
    localparam int COLUMN_TO_COLUMN_DELAY    = 1;

    // Pins sampled together from the controller
    typedef struct packed {
        logic              cke;
        logic              csN;
        logic              rasN;
        logic              casN;
        logic              weN;
        logic              dqm;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] dq;
    } sct_pins_type;

    localparam sct_pins_type PINS_RST = '{cke: 1'h0, csN: 1'h1, rasN: 1'h1, casN: 1'h1,
                                          weN: 1'h1, dqm: 1'h1, addr: 12'h000, dq: 8'h00};

    // Commands, low three bits are {ras, cas, we} with chip select low
    typedef enum logic [3:0] {
        CMD_MRS   = 4'h0,
        CMD_REF   = 4'h1,
        CMD_PRE   = 4'h2,
        CMD_ACT   = 4'h3,
        CMD_WR    = 4'h4,
        CMD_RD    = 4'h5,
        CMD_BST   = 4'h6,
        CMD_NOP   = 4'h7,
        CMD_DESEL = 4'h8
    } sct_cmd_type;

    // Power states, Gray coded along entry; the step from exit back to active flips both bits
    typedef enum logic [1:0] {
        PWR_ACTIVE = 2'h0,
        PWR_SELF   = 2'h1,
        PWR_EXIT   = 2'h3
    } sct_pwr_type;

endpackage : sct_pkg

// >>> logic/sct_sdram_device.sv
// Dual bank synchronous DRAM device: command decode, bursts, masks, self refresh exit
// Operation
// - Self refresh exit starts on second rising edge after clock gate high.
// - Column commands to one bank are accepted on every clock edge.
// - Read mask sampled high floats data outputs two clocks later.
// - Write mask blocks the data word of the same clock edge.
`timescale 1ns/1ps

module sct_sdram_device #(
    parameter int COL_BITS = 4                    // Column address bits; 2 ** COL_BITS columns held per bank
) (
    input  wire logic                       sys_clk,      // Block clock, 200 MHz
    input  wire logic                       reset,        // Synchronous, active high
    input  wire logic                       clkEnable,    // Freezes all state when low
    input  wire logic                       sdramClk,     // Link clock from controller
    input  wire logic                       cke,          // Clock gate pin
    input  wire logic                       csN,          // Chip select, active low
    input  wire logic                       rasN,         // Row strobe, active low
    input  wire logic                       casN,         // Column strobe, active low
    input  wire logic                       weN,          // Write enable, active low
    input  wire logic [sct_pkg::ADDR_W-1:0] addr,         // Address and bank select
    input  wire logic                       dqm,          // Data mask
    input  wire logic [sct_pkg::DATA_W-1:0] dqIn,         // Data from controller
    output logic      [sct_pkg::DATA_W-1:0] dqOut,        // Read data to controller
    output logic                            dqOe,         // Data pin drive enable
    output logic                            selfRefresh,  // In self refresh or exit
    output logic      [1:0]                 bankOpen,     // Row open per bank
    output logic      [3:0]                 refreshCount, // Saturating refresh tally
    output logic                            modeSet,      // Mode word written
    output logic      [sct_pkg::CL_W-1:0]   casLatency    // Programmed read latency
);

    // Burst of eight must fit in the column space
    initial begin
        if (COL_BITS < 3 || COL_BITS > 10) begin
            $error("COL_BITS must lie between 3 and 10");
        end
    end

    localparam int WORDS = 2 * (2 ** COL_BITS);

    // Pin sampling: two flops, plus a third stage of the link clock for edge finding
    sct_pkg::sct_pins_type pinsRaw;
    sct_pkg::sct_pins_type pinsMeta;
    sct_pkg::sct_pins_type pinsSync;
    logic                  clkMeta;
    logic                  clkSync;
    logic                  clkLast;

    assign pinsRaw = '{cke: cke, csN: csN, rasN: rasN, casN: casN, weN: weN,
                       dqm: dqm, addr: addr, dq: dqIn};

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            pinsMeta <= sct_pkg::PINS_RST;
            pinsSync <= sct_pkg::PINS_RST;
            clkMeta  <= 1'h0;
            clkSync  <= 1'h0;
            clkLast  <= 1'h0;
        end else if (clkEnable) begin
            pinsMeta <= pinsRaw;
            pinsSync <= pinsMeta;
            clkMeta  <= sdramClk;
            clkSync  <= clkMeta;
            clkLast  <= clkSync;
        end
    end

    // Edge and command decode; pins share the clock's delay, so they align with its edge
    logic                 ckeLast;
    logic                 dqmLast;
    sct_pkg::sct_pwr_type power;
    sct_pkg::sct_pwr_type next_power;
    logic [sct_pkg::BL_W-1:0] burstCode;
    wire                  linkEdge = clkSync & ~clkLast;
    wire                  clkValid = linkEdge & ckeLast & (power == sct_pkg::PWR_ACTIVE);
    wire sct_pkg::sct_cmd_type cmd = pinsSync.csN ? sct_pkg::CMD_DESEL :
        sct_pkg::sct_cmd_type'({1'h0, pinsSync.rasN, pinsSync.casN, pinsSync.weN});
    wire                  cmdBank = pinsSync.addr[sct_pkg::BANK_BIT];
    wire                  preAll  = pinsSync.addr[sct_pkg::PRE_ALL_BIT];
    wire                  colCmd  = (cmd == sct_pkg::CMD_RD) | (cmd == sct_pkg::CMD_WR);

    // Self refresh: first edge with the gate high arms, the second registers the exit
    always_comb begin
        next_power = power;
        case (power)
            sct_pkg::PWR_ACTIVE: begin
                if (ckeLast && !pinsSync.cke && cmd == sct_pkg::CMD_REF) begin
                    next_power = sct_pkg::PWR_SELF;
                end
            end
            sct_pkg::PWR_SELF: begin
                if (pinsSync.cke) begin
                    next_power = sct_pkg::PWR_EXIT;
                end
            end
            sct_pkg::PWR_EXIT: begin
                next_power = pinsSync.cke ? sct_pkg::PWR_ACTIVE :
                                            sct_pkg::PWR_SELF;
            end
            default: next_power = sct_pkg::PWR_ACTIVE;
        endcase
    end

    // Clock gate history taken on every link edge; mask history only on edges where the gate was high
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            power   <= sct_pkg::PWR_ACTIVE;
            ckeLast <= sct_pkg::RST_CKE_LAST;
            dqmLast <= 1'h1;
        end else if (clkEnable && linkEdge) begin
            power   <= next_power;
            ckeLast <= pinsSync.cke;
            if (ckeLast) begin
                dqmLast <= pinsSync.dqm;
            end
        end
    end

    // Burst length decode; full page runs through the whole column space
    function automatic logic [COL_BITS:0] span_of(input logic [sct_pkg::BL_W-1:0] code);
        logic [COL_BITS:0] span;
        span = (COL_BITS + 1)'(1);
        if (code == sct_pkg::BL_FULL_PAGE) begin
            span = (COL_BITS + 1)'(1) << COL_BITS;
        end else if (code <= sct_pkg::BL_MAX_POW) begin
            span = (COL_BITS + 1)'(1) << code;
        end
        return span;
    endfunction : span_of

    // Burst tracking: the last column touched and how many words remain
    logic                burstActive;
    logic                burstRead;
    logic                burstBank;
    logic [COL_BITS-1:0] burstCol;
    logic [COL_BITS:0]   burstLeft;
    wire  [COL_BITS:0]   burstSpan = span_of(burstCode);
    wire  [COL_BITS-1:0] wrapMask  = COL_BITS'(burstSpan - (COL_BITS + 1)'(1));
    wire  [COL_BITS-1:0] colStep   = COL_BITS'(burstCol + COL_BITS'(1));
    wire  stopBurst = (cmd == sct_pkg::CMD_BST) |
                      ((cmd == sct_pkg::CMD_PRE) & (preAll | (cmdBank == burstBank)));
    wire  contBurst = burstActive & (burstLeft != '0) & ~stopBurst;
    // A new column command always wins, so one can land on every edge
    wire  wordHere  = colCmd | contBurst;
    wire  [COL_BITS-1:0] wordCol = colCmd ? pinsSync.addr[COL_BITS-1:0] :
                                   ((burstCol & ~wrapMask) | (colStep & wrapMask));
    wire  wordBank  = colCmd ? cmdBank : burstBank;
    wire  wordRead  = colCmd ? (cmd == sct_pkg::CMD_RD) : burstRead;
    wire  [COL_BITS:0] next_left = colCmd ? (COL_BITS + 1)'(burstSpan - (COL_BITS + 1)'(1)) :
                                   (COL_BITS + 1)'(burstLeft - (COL_BITS + 1)'(1));

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            burstActive <= 1'h0;
            burstRead   <= 1'h0;
            burstBank   <= 1'h0;
            burstCol    <= '0;
            burstLeft   <= '0;
        end else if (clkEnable && clkValid) begin
            burstActive <= wordHere;
            if (wordHere) begin
                burstRead <= wordRead;
                burstBank <= wordBank;
                burstCol  <= wordCol;
                burstLeft <= next_left;
            end
        end
    end

    // Storage; rows alias onto one column set per bank to keep the array small
    logic [sct_pkg::DATA_W-1:0] mem [WORDS];
    wire  [COL_BITS:0]          wordIdx = {wordBank, wordCol};
    wire  [sct_pkg::DATA_W-1:0] rdWord  = mem[wordIdx];
    // Mask on the same edge as the data blocks the write outright
    wire  writeNow = clkValid & wordHere & ~wordRead & ~pinsSync.dqm;

    always_ff @(posedge sys_clk) begin
        if (clkEnable && writeNow) begin
            mem[wordIdx] <= pinsSync.dq;
        end
    end

    // Read pipeline; the latency picks how far down the data is taken
    logic [1:0]                 pipeValid;
    logic [sct_pkg::DATA_W-1:0] pipeData [2];
    wire  latOne   = casLatency == sct_pkg::CL_W'(1);
    wire  latTwo   = casLatency == sct_pkg::CL_W'(2);
    wire  tapValid = latOne ? (wordHere & wordRead) : (latTwo ? pipeValid[0] : pipeValid[1]);
    wire  [sct_pkg::DATA_W-1:0] tapData = latOne ? rdWord : (latTwo ? pipeData[0] : pipeData[1]);

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            pipeValid   <= 2'h0;
            pipeData[0] <= '0;
            pipeData[1] <= '0;
        end else if (clkEnable && clkValid) begin
            pipeValid   <= {pipeValid[0], wordHere & wordRead};
            pipeData[0] <= rdWord;
            pipeData[1] <= pipeData[0];
        end
    end

    // Output stage: the mask seen one edge back floats the word for the edge after next
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            dqOut <= '0;
            dqOe  <= 1'h0;
        end else if (clkEnable && linkEdge) begin
            if (clkValid) begin
                dqOut <= tapData;
                dqOe  <= tapValid & ~dqmLast;
            end else if (power != sct_pkg::PWR_ACTIVE) begin
                dqOe  <= 1'h0;
            end
        end
    end

    // Mode word and refresh tally; suspended edges hold both, while selfRefresh follows every link edge
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            casLatency   <= sct_pkg::RST_CAS_LATENCY;
            burstCode    <= sct_pkg::RST_BURST_CODE;
            modeSet      <= 1'h0;
            refreshCount <= 4'h0;
            selfRefresh  <= 1'h0;
        end else if (clkEnable && linkEdge) begin
            selfRefresh <= next_power != sct_pkg::PWR_ACTIVE;
            if (clkValid && cmd == sct_pkg::CMD_MRS) begin
                casLatency <= pinsSync.addr[sct_pkg::CL_LSB +: sct_pkg::CL_W];
                burstCode  <= pinsSync.addr[sct_pkg::BL_LSB +: sct_pkg::BL_W];
                modeSet    <= 1'h1;
            end
            if (clkValid && cmd == sct_pkg::CMD_REF && refreshCount != sct_pkg::REFRESH_SAT) begin
                refreshCount <= refreshCount + 4'h1;
            end
        end
    end

    // Row state per bank: activate opens, precharge closes one or both
    for (genvar b = 0; b < 2; b++) begin : g_bank
        wire hitBank = cmdBank == 1'(b);
        always_ff @(posedge sys_clk) begin
            if (reset) begin
                bankOpen[b] <= 1'h0;
            end else if (clkEnable && clkValid) begin
                if (cmd == sct_pkg::CMD_ACT && hitBank) begin
                    bankOpen[b] <= 1'h1;
                end else if (cmd == sct_pkg::CMD_PRE && (preAll || hitBank)) begin
                    bankOpen[b] <= 1'h0;
                end
            end
        end
    end

endmodule : sct_sdram_device

// >>> tb/sct_ctl_model.sv
// Memory controller model: link clock, command pins, power-up sequence
`timescale 1ns/1ps

module sct_ctl_model (
    input  wire logic      sys_clk, // Block clock, paces pin changes
    output logic           sdramClk, // Link clock, free running
    output sct_pkg::sct_pins_type pins // Command, address, mask, data
);
    int   edgeNo = 0;
    logic busy   = 1'h0;
    logic ckeLvl = 1'h1;

    // 48 ns link clock, above every latency minimum, phase unrelated
    initial begin
        pins = sct_pkg::PINS_RST;
        sdramClk = 1'h0;
        #7.3;
        forever #24 sdramClk = ~sdramClk;
    end

    always @(posedge sdramClk) edgeNo <= edgeNo + 1;

    // Idle edges get a no-op; data toggles so a stale word never passes
    always @(negedge sdramClk) begin
        @(posedge sys_clk);
        #1;
        if (!busy) pins <= '{ckeLvl, 1'h0, 1'h1, 1'h1, 1'h1, 1'h0, pins.addr, ~pins.dq};
    end

    // One command at the link edge after the next falling edge, held through that edge
    task automatic issue(input sct_pkg::sct_cmd_type c, input logic [11:0] a,
                         input logic m, input logic [7:0] d, input logic k);
        busy = 1'h1;
        @(negedge sdramClk);
        @(posedge sys_clk);
        #1;
        ckeLvl = k;
        pins <= '{k, c[3], c[2], c[1], c[0], m, a, d};
        @(posedge sdramClk);
        #1;
        busy = 1'h0;
    endtask : issue

    task automatic gap(input int n);
        repeat (n) @(posedge sdramClk);
        #1;
    endtask : gap

    // Pause, precharge both banks, eight refreshes a row cycle apart
    task automatic init();
        #200000;
        issue(sct_pkg::CMD_PRE, 12'h400, 1'h0, 8'h00, 1'h1);
        repeat (8) begin
            issue(sct_pkg::CMD_REF, 12'h000, 1'h0, 8'h00, 1'h1);
            gap(1);
        end
    endtask : init
endmodule : sct_ctl_model

// >>> tb/sct_sdram_device_asserts.sv
// Port-level checks for the SDRAM device timing block
`timescale 1ns/1ps

module sct_sdram_device_asserts #(
    parameter int COL_BITS = 4 // Column address bits, 2 ** COL_BITS columns per bank
) (
    input wire logic       sys_clk,      // Block clock
    input wire logic       reset,        // Synchronous reset
    input wire logic       sdramClk,     // Link clock
    input wire logic       cke,          // Clock gate pin
    input wire logic       dqm,          // Data mask
    input wire logic       dqOe,         // Data drive enable
    input wire logic       selfRefresh,  // Self refresh flag
    input wire logic [1:0] bankOpen,     // Open rows
    input wire logic [3:0] refreshCount, // Refresh tally
    input wire logic       modeSet,      // Mode written
    input wire logic [2:0] casLatency    // Read latency
);
    logic       clkPrev;
    logic [1:0] dqmHist;
    wire        linkRise = sdramClk & ~clkPrev;

    // Mask at last two link edges; no synchroniser, so it leads the design
    always_ff @(posedge sys_clk) begin
        clkPrev <= sdramClk;
        if (reset) dqmHist <= 2'h0;
        else if (linkRise) dqmHist <= {dqmHist[0], dqm};
    end

    default clocking @(posedge sys_clk); endclocking
    default disable iff (reset);

    property p_reset_state;
        $fell(reset) |-> !dqOe && !selfRefresh && !modeSet && bankOpen == 2'h0
            && refreshCount == 4'h0 && casLatency == sct_pkg::RST_CAS_LATENCY;
    endproperty
    a_reset_state: assert property (p_reset_state) else $error("state after reset wrong");
    property p_exit_late;
        $fell(selfRefresh) |-> cke && $past(cke, 12);
    endproperty
    a_exit_late: assert property (p_exit_late) else $error("self refresh left early");
    property p_exit_hold;
        selfRefresh && !cke |=> selfRefresh;
    endproperty
    a_exit_hold: assert property (p_exit_hold) else $error("exit with gate low");
    property p_read_quiet;
        $rose(dqOe) |-> !dqmHist[1];
    endproperty
    a_read_quiet: assert property (p_read_quiet) else $error("masked word driven");
    property p_refresh_step;
        $changed(refreshCount) && !$past(reset) |-> refreshCount == $past(refreshCount) + 4'h1;
    endproperty
    a_refresh_step: assert property (p_refresh_step) else $error("refresh tally jumped");

    c_read: cover property ($rose(dqOe));
    c_masked: cover property ($fell(dqOe) && dqmHist[1]);
    c_exit: cover property ($fell(selfRefresh));
endmodule : sct_sdram_device_asserts

bind sct_sdram_device sct_sdram_device_asserts #(.COL_BITS(COL_BITS)) u_chk (
    .sys_clk(sys_clk), .reset(reset), .sdramClk(sdramClk), .cke(cke), .dqm(dqm),
    .dqOe(dqOe), .selfRefresh(selfRefresh), .bankOpen(bankOpen),
    .refreshCount(refreshCount), .modeSet(modeSet), .casLatency(casLatency));

// >>> tb/sct_sdram_device_tb.sv
// Self-checking bench for the SDRAM device timing block
`timescale 1ns/1ps

module sct_sdram_device_tb;
    typedef struct {logic [7:0] data; int at;} sct_note_type;
    logic sys_clk, reset, sdramClk, dqOe, selfRefresh, modeSet;
    logic clkEnable = 1'h1;
    logic [7:0] dqOut, d;
    logic [1:0] bankOpen;
    logic [3:0] refreshCount;
    logic [2:0] casLatency;
    logic [7:0] mem [8];
    sct_pkg::sct_pins_type pins;
    sct_note_type notes [$];
    int nMismatch = 0;
    int checksDone = 0;
    int e0;

    sct_ctl_model ctl (.sys_clk(sys_clk), .sdramClk(sdramClk), .pins(pins));
    sct_sdram_device #(.COL_BITS(4)) dut (
        .sys_clk(sys_clk), .reset(reset), .clkEnable(clkEnable), .sdramClk(sdramClk),
        .cke(pins.cke), .csN(pins.csN), .rasN(pins.rasN), .casN(pins.casN),
        .weN(pins.weN), .addr(pins.addr), .dqm(pins.dqm), .dqIn(pins.dq),
        .dqOut(dqOut), .dqOe(dqOe), .selfRefresh(selfRefresh), .bankOpen(bankOpen),
        .refreshCount(refreshCount), .modeSet(modeSet), .casLatency(casLatency));

    task automatic cmpStat(input string w, input logic [7:0] e, input logic [7:0] g);
        checksDone++;
        if (g !== e) begin
            nMismatch++;
            $display("Error %s expected %h seen %h", w, e, g);
        end
    endtask : cmpStat

    task automatic cmpWord(input sct_note_type n, input logic [7:0] g, input int at);
        checksDone++;
        if (g !== n.data || at != n.at) begin
            nMismatch++;
            $display("Error read word expected %h@%0d seen %h@%0d", n.data, n.at, g, at);
        end
    endtask : cmpWord

    task automatic note(input logic [7:0] v, input int at);
        notes.push_back('{v, at});
    endtask : note

    task automatic settle();
        repeat (6) @(posedge sys_clk);
        #1;
    endtask : settle

    task automatic tallyAndFinish();
        $display("Checks %0d mismatches %0d", checksDone, nMismatch);
        if (nMismatch == 0 && checksDone > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : tallyAndFinish

    initial begin
        sys_clk = 1'h0;
        forever #2.5 sys_clk = ~sys_clk;
    end

    // Each driven word is matched to the oldest note, edge number included
    always @(posedge sdramClk) begin
        #1;
        if (dqOe === 1'h1) begin
            if (notes.size() == 0) note(8'h00, -1);
            cmpWord(notes.pop_front(), dqOut, ctl.edgeNo);
        end
    end

    initial begin
        #400000;
        nMismatch++;
        $display("Error watchdog expected end seen timeout");
        tallyAndFinish();
    end

    initial begin
        reset = 1'h1;
        void'($urandom(32'h8572D1BC));
        repeat (6) @(posedge sys_clk);
        #1;
        reset = 1'h0;
        cmpStat("casLatency", 8'h03, {5'h00, casLatency});
        ctl.init();
        settle();
        cmpStat("refreshCount", 8'h08, {4'h0, refreshCount});
        // Frozen block must miss a refresh issued meanwhile; pins are idle again on release
        clkEnable = 1'h0;
        ctl.issue(sct_pkg::CMD_REF, 12'h000, 1'h0, 8'h00, 1'h1);
        ctl.gap(2);
        @(posedge sys_clk);
        #1;
        clkEnable = 1'h1;
        settle();
        cmpStat("frozen", 8'h08, {4'h0, refreshCount});
        $display("Test init done");
        for (int cl = 1; cl <= 3; cl++) begin
            ctl.issue(sct_pkg::CMD_PRE, 12'h400, 1'h0, 8'h00, 1'h1);
            ctl.issue(sct_pkg::CMD_MRS, {5'h00, 3'(cl), 4'h3}, 1'h0, 8'h00, 1'h1);
            ctl.issue(sct_pkg::CMD_ACT, 12'h800, 1'h0, 8'h00, 1'h1);
            ctl.issue(sct_pkg::CMD_ACT, 12'h000, 1'h0, 8'h00, 1'h1);
            cmpStat("mode", {4'h1, 1'h0, 3'(cl)}, {3'h0, modeSet, 1'h0, casLatency});
            // Two bursts back to back, one word masked in the second
            for (int p = 0; p < 2; p++) begin
                for (int k = 0; k < 8; k++) begin
                    d = 8'($urandom);
                    ctl.issue(k == 0 ? sct_pkg::CMD_WR : sct_pkg::CMD_NOP, 12'h000,
                              1'(p == 1 && k == 3), d, 1'h1);
                    if (p == 0 || k != 3) mem[k] = d;
                end
            end
            cmpStat("bankOpen", 8'h03, {6'h00, bankOpen});
            ctl.issue(sct_pkg::CMD_RD, 12'h000, 1'h0, 8'h00, 1'h1);
            e0 = ctl.edgeNo;
            for (int k = 0; k < 8; k++) if (cl + k != 5) note(mem[k], e0 + cl + k);
            for (int k = 0; k < 3; k++) ctl.issue(sct_pkg::CMD_NOP, 12'h000, 1'(k == 2), d, 1'h1);
            ctl.gap(10);
            ctl.issue(sct_pkg::CMD_RD, 12'h004, 1'h0, 8'h00, 1'h1);
            note(mem[4], ctl.edgeNo + cl);
            ctl.issue(sct_pkg::CMD_RD, 12'h006, 1'h0, 8'h00, 1'h1);
            e0 = ctl.edgeNo;
            for (int k = 0; k < 8; k++) note(mem[(6 + k) % 8], e0 + cl + k);
            ctl.gap(12); // Write recovery long past
            $display("Test latency %0d done", cl);
        end
        ctl.issue(sct_pkg::CMD_PRE, 12'h400, 1'h0, 8'h00, 1'h1);
        ctl.issue(sct_pkg::CMD_REF, 12'h000, 1'h0, 8'h00, 1'h0);
        ctl.gap(3);
        // The entry edge is a valid refresh edge, so the tally steps once more
        cmpStat("entry", 8'h19, {3'h0, selfRefresh, refreshCount});
        cmpStat("bankOpen", 8'h00, {6'h00, bankOpen});
        ctl.issue(sct_pkg::CMD_NOP, 12'h000, 1'h0, 8'h00, 1'h1);
        settle();
        cmpStat("selfRefresh", 8'h01, {7'h00, selfRefresh});
        ctl.issue(sct_pkg::CMD_NOP, 12'h000, 1'h0, 8'h00, 1'h1);
        settle();
        cmpStat("selfRefresh", 8'h00, {7'h00, selfRefresh});
        ctl.gap(2); // Row cycle after exit
        ctl.issue(sct_pkg::CMD_ACT, 12'h000, 1'h0, 8'h00, 1'h1);
        ctl.issue(sct_pkg::CMD_RD, 12'h002, 1'h0, 8'h00, 1'h1);
        e0 = ctl.edgeNo;
        for (int k = 0; k < 3; k++) note(mem[2 + k], e0 + 3 + k);
        // Burst stop on the third edge after the read keeps three of eight words
        for (int k = 0; k < 3; k++) begin
            ctl.issue(k == 2 ? sct_pkg::CMD_BST : sct_pkg::CMD_NOP, 12'h000, 1'h0, 8'h00, 1'h1);
        end
        ctl.gap(12);
        cmpStat("pending", 8'h00, 8'(notes.size()));
        $display("Test self refresh done");
        tallyAndFinish();
    end
endmodule : sct_sdram_device_tb
